// >>> hw/fpes_top.sv
// Purpose: Program, erase and verify sequencer for a 64K-byte flash with page buffer
// Assumes: All inputs are on SYS_CLK; the flash returns read data one cycle after rd
// Notes: Register access through the function-register port only
`timescale 1ns/100ps
`include "fpes_regs.svh"
module fpes_top (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic CE,
    input wire fpes_pkg::fpes_sfr_req_type SFR_REQ,
    output logic [7:0] SFR_RDATA,
    input wire fpes_pkg::fpes_mem_wr_type MEM_WR,
    input wire logic ONCHIP_DEBUG_MODE,
    output fpes_pkg::fpes_flash_cmd_type FL_CMD,
    input wire logic [7:0] FL_RDATA
);
    import fpes_pkg::*;

    // ------------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------------
    fpes_regs_type s_ff;
    fpes_regs_type nxt_s;
    logic program_select, ers, verify_select, psel, pe_mode, vfy_mode, plain_mode;
    logic wr_data, wr_ctrl;
    logic [7:0] expect_byte;

    assign program_select = s_ff.mode[`FPES_MODE_PGM];
    assign ers = s_ff.mode[`FPES_MODE_ERASE];
    assign verify_select = s_ff.mode[`FPES_MODE_VFY];
    assign psel = s_ff.mode[`FPES_MODE_BUFFER_SELECT];
    assign plain_mode = !program_select && !ers && !verify_select;
    assign pe_mode = s_ff.prog_mode && s_ff.mode[`FPES_MODE_FSEL] && s_ff.mode[`FPES_MODE_FEEN]
        && (program_select != ers) && !verify_select;
    assign vfy_mode = s_ff.prog_mode && verify_select && (program_select || ers);
    assign wr_data = SFR_REQ.wr && (SFR_REQ.addr == `FPES_ADDR_DATA);
    assign wr_ctrl = SFR_REQ.wr && (SFR_REQ.addr == `FPES_ADDR_CTRL);
    assign expect_byte = program_select ? s_ff.pbuf[s_ff.fl_addr[5:0]] : `FPES_ERASED_BYTE;

    // ------------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------------
    // Address registers are write-only; reading them shows the write checksum
    function automatic logic [7:0] read_mux(input fpes_regs_type r, input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            `FPES_ADDR_MODE: v = r.mode;
            `FPES_ADDR_STATUS: v = {r.done, r.vfy_good, 2'b00, r.rom_int,
                r.mode[`FPES_MODE_PGM], r.mode[`FPES_MODE_ERASE], r.mode[`FPES_MODE_VFY]};
            `FPES_ADDR_TCMP: v = r.tcmp;
            `FPES_ADDR_PAGE_HIGH: v = r.csum[23:16];
            `FPES_ADDR_PAGE_MID: v = r.csum[15:8];
            `FPES_ADDR_PAGE_LOW: v = r.csum[7:0];
            `FPES_ADDR_DATA: v = r.data;
            `FPES_ADDR_CTRL: v = {r.bulk_en, 3'b000, r.cmd_wr, r.cmd_rd, r.ferst_n, r.pbrst_n};
            default: v = 8'h00;
        endcase
        return v;
    endfunction : read_mux

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        nxt_s = s_ff;
        nxt_s.cmd_wr = 1'b0;
        nxt_s.cmd_rd = 1'b0;
        nxt_s.ferst_n = 1'b1;
        nxt_s.pbrst_n = 1'b1;
        nxt_s.fl_wr = 1'b0;
        nxt_s.fl_rd = 1'b0;
        nxt_s.fl_perase = 1'b0;
        nxt_s.fl_berase = 1'b0;
        nxt_s.rd_pend = s_ff.fl_rd;
        if (SFR_REQ.rd) begin
            nxt_s.rdata = read_mux(s_ff, SFR_REQ.addr);
        end
        if (SFR_REQ.wr) begin
            case (SFR_REQ.addr)
                `FPES_ADDR_MODE: nxt_s.mode = SFR_REQ.wdata;
                `FPES_ADDR_STATUS: begin
                    nxt_s.vfy_good = SFR_REQ.wdata[`FPES_STAT_VGOOD];
                    nxt_s.rom_int = SFR_REQ.wdata[`FPES_STAT_INT];
                end
                `FPES_ADDR_TCMP: nxt_s.tcmp = SFR_REQ.wdata;
                `FPES_ADDR_PAGE_HIGH: nxt_s.page_addr[23:16] = SFR_REQ.wdata;
                `FPES_ADDR_PAGE_MID: nxt_s.page_addr[15:8] = SFR_REQ.wdata;
                `FPES_ADDR_PAGE_LOW: nxt_s.page_addr[7:0] = SFR_REQ.wdata;
                `FPES_ADDR_DATA: begin
                    nxt_s.data = SFR_REQ.wdata;
                    if (psel && s_ff.state == ST_IDLE) begin
                        nxt_s.pbuf[s_ff.pidx] = SFR_REQ.wdata;
                        nxt_s.pidx = s_ff.pidx + 6'h01;
                        nxt_s.csum = s_ff.csum + {16'h0000, SFR_REQ.wdata};
                    end
                    if (s_ff.seen_first && SFR_REQ.wdata == `FPES_ENTRY_SECOND) begin
                        nxt_s.prog_mode = 1'b1;
                    end
                    nxt_s.seen_first = (SFR_REQ.wdata == `FPES_ENTRY_FIRST);
                end
                `FPES_ADDR_CTRL: begin
                    nxt_s.bulk_en = SFR_REQ.wdata[`FPES_CTRL_BULK];
                    nxt_s.cmd_wr = SFR_REQ.wdata[`FPES_CTRL_WRITE];
                    nxt_s.cmd_rd = SFR_REQ.wdata[`FPES_CTRL_READ];
                    nxt_s.ferst_n = SFR_REQ.wdata[`FPES_CTRL_FERST];
                    nxt_s.pbrst_n = SFR_REQ.wdata[`FPES_CTRL_PBRST];
                    nxt_s.direct_addr = MEM_WR.addr;
                end
                default: ;
            endcase
        end
        // Unlock sequence only counts while the debug link holds the core
        if (!ONCHIP_DEBUG_MODE) begin
            nxt_s.unlock_step = 2'h0;
        end else if (MEM_WR.wr) begin
            case (s_ff.unlock_step)
                2'h0: nxt_s.unlock_step = (MEM_WR.addr == `FPES_UNLOCK_ADDR_A
                    && MEM_WR.wdata == `FPES_UNLOCK_DATA_1) ? 2'h1 : 2'h0;
                2'h1: nxt_s.unlock_step = (MEM_WR.addr == `FPES_UNLOCK_ADDR_B
                    && MEM_WR.wdata == `FPES_UNLOCK_DATA_2) ? 2'h2 : 2'h0;
                2'h2: begin
                    nxt_s.unlock_step = 2'h0;
                    if (MEM_WR.addr == `FPES_UNLOCK_ADDR_A
                        && MEM_WR.wdata == `FPES_UNLOCK_DATA_3) begin
                        nxt_s.prog_mode = 1'b1;
                    end
                end
                default: nxt_s.unlock_step = 2'h0;
            endcase
        end
        if (wr_ctrl && SFR_REQ.wdata[5:4] == `FPES_EXIT_CODE) begin
            nxt_s.prog_mode = 1'b0;
            nxt_s.seen_first = 1'b0;
            nxt_s.unlock_step = 2'h0;
        end
        // Buffer reset acts on the pulse, one clock after the write
        if (!s_ff.pbrst_n) begin
            if (!psel) begin
                nxt_s.pbuf = '0;
                nxt_s.pidx = 6'h00;
            end else begin
                nxt_s.csum = 24'h00_0000;
            end
        end
        // Timer runs only while a program or erase is in flight
        if (s_ff.state == ST_COPY || s_ff.state == ST_WAIT) begin
            nxt_s.prescale = s_ff.prescale + 7'h01;
            if (s_ff.prescale == `FPES_PRESCALE_LAST) begin
                nxt_s.timer = s_ff.timer + 10'h001;
            end
        end
        case (s_ff.state)
            ST_IDLE: begin
                if (s_ff.cmd_wr && pe_mode) begin
                    nxt_s.done = 1'b0;
                    nxt_s.rom_int = 1'b0;
                    nxt_s.timer = 10'h000;
                    nxt_s.prescale = 7'h00;
                    nxt_s.widx = 6'h00;
                    nxt_s.fl_addr = {s_ff.page_addr[15:6], 6'h00};
                    if (program_select) begin
                        nxt_s.state = ST_COPY;
                    end else begin
                        nxt_s.fl_berase = s_ff.bulk_en;
                        nxt_s.fl_perase = !s_ff.bulk_en;
                        nxt_s.state = ST_WAIT;
                    end
                end else if (s_ff.cmd_rd && vfy_mode) begin
                    nxt_s.done = 1'b0;
                    nxt_s.rom_int = 1'b0;
                    nxt_s.vfy_good = 1'b1;
                    nxt_s.widx = 6'h00;
                    nxt_s.issued_all = 1'b0;
                    nxt_s.state = ST_VERIFY;
                end else if (plain_mode && (s_ff.cmd_rd || s_ff.cmd_wr)) begin
                    nxt_s.fl_addr = s_ff.direct_addr;
                    nxt_s.fl_wdata = s_ff.data;
                    nxt_s.fl_rd = s_ff.cmd_rd;
                    nxt_s.fl_wr = s_ff.cmd_wr && !s_ff.cmd_rd;
                end
                if (s_ff.rd_pend) begin
                    nxt_s.data = FL_RDATA;
                end
            end
            ST_COPY: begin
                nxt_s.fl_wr = 1'b1;
                nxt_s.fl_addr = {s_ff.page_addr[15:6], s_ff.widx};
                nxt_s.fl_wdata = s_ff.pbuf[s_ff.widx];
                nxt_s.widx = s_ff.widx + 6'h01;
                if (s_ff.widx == `FPES_PAGE_LAST) begin
                    nxt_s.state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (s_ff.timer == {2'b00, s_ff.tcmp}) begin
                    nxt_s.state = ST_IDLE;
                    nxt_s.done = 1'b1;
                    nxt_s.rom_int = 1'b1;
                end
            end
            ST_VERIFY: begin
                // One read in flight at a time keeps fl_addr pointing at the byte compared
                if (!s_ff.issued_all && !s_ff.fl_rd && !s_ff.rd_pend) begin
                    nxt_s.fl_rd = 1'b1;
                    nxt_s.fl_addr = {s_ff.page_addr[15:6], s_ff.widx};
                    nxt_s.widx = s_ff.widx + 6'h01;
                    nxt_s.issued_all = (s_ff.widx == `FPES_PAGE_LAST);
                end
                if (s_ff.rd_pend) begin
                    if (FL_RDATA != expect_byte) begin
                        nxt_s.vfy_good = 1'b0;
                    end
                    if (s_ff.fl_addr[5:0] == `FPES_PAGE_LAST) begin
                        nxt_s.state = ST_IDLE;
                        nxt_s.done = 1'b1;
                        nxt_s.rom_int = 1'b1;
                    end
                end
            end
            default: nxt_s.state = ST_IDLE;
        endcase
        // Control reset aborts any operation; flash strobes are withdrawn too
        if (!s_ff.ferst_n) begin
            nxt_s.state = ST_IDLE;
            nxt_s.timer = 10'h000;
            nxt_s.prescale = 7'h00;
            nxt_s.done = 1'b1;
            nxt_s.fl_wr = 1'b0;
            nxt_s.fl_rd = 1'b0;
            nxt_s.fl_perase = 1'b0;
            nxt_s.fl_berase = 1'b0;
            nxt_s.rd_pend = 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            s_ff <= '0;
            s_ff.state <= ST_IDLE;
            s_ff.done <= 1'b1;
            s_ff.ferst_n <= 1'b1;
            s_ff.pbrst_n <= 1'b1;
        end else if (CE) begin
            s_ff <= nxt_s;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign SFR_RDATA = s_ff.rdata;
    assign FL_CMD.addr = s_ff.fl_addr;
    assign FL_CMD.wdata = s_ff.fl_wdata;
    assign FL_CMD.wr = s_ff.fl_wr;
    assign FL_CMD.rd = s_ff.fl_rd;
    assign FL_CMD.page_erase = s_ff.fl_perase;
    assign FL_CMD.bulk_erase = s_ff.fl_berase;
    assign FL_CMD.otp = s_ff.mode[`FPES_MODE_OTP_SELECT];
    assign FL_CMD.verify = vfy_mode;
    assign FL_CMD.busy = (s_ff.state != ST_IDLE);

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST || !CE);

    sequence seq_unlock_a;
        MEM_WR.wr && ONCHIP_DEBUG_MODE && MEM_WR.addr == `FPES_UNLOCK_ADDR_A
            && MEM_WR.wdata == `FPES_UNLOCK_DATA_1;
    endsequence
    sequence seq_unlock_b;
        MEM_WR.wr && ONCHIP_DEBUG_MODE && MEM_WR.addr == `FPES_UNLOCK_ADDR_B
            && MEM_WR.wdata == `FPES_UNLOCK_DATA_2;
    endsequence
    sequence seq_unlock_c;
        MEM_WR.wr && ONCHIP_DEBUG_MODE && MEM_WR.addr == `FPES_UNLOCK_ADDR_A
            && MEM_WR.wdata == `FPES_UNLOCK_DATA_3 && !wr_ctrl;
    endsequence
    sequence seq_pgm_start;
        s_ff.state == ST_IDLE && s_ff.cmd_wr && pe_mode && program_select && s_ff.ferst_n;
    endsequence

    AST_UNLOCK_ORDER: assert property (seq_unlock_a ##1 (ONCHIP_DEBUG_MODE && !MEM_WR.wr)
        ##1 seq_unlock_b ##1 (ONCHIP_DEBUG_MODE && !MEM_WR.wr) ##1 seq_unlock_c
        |=> s_ff.prog_mode) else $error("unlock sequence did not enter program mode");
    AST_ENTRY_ORDER: assert property (wr_data && s_ff.seen_first
        && SFR_REQ.wdata == `FPES_ENTRY_SECOND |=> s_ff.prog_mode)
        else $error("data register entry sequence ignored");
    AST_EXIT_CODE: assert property (wr_ctrl && SFR_REQ.wdata[5:4] == `FPES_EXIT_CODE
        |=> !s_ff.prog_mode) else $error("exit code did not leave program mode");
    AST_KEEP_MODE: assert property (s_ff.prog_mode && wr_ctrl
        && SFR_REQ.wdata[5:4] != `FPES_EXIT_CODE |=> s_ff.prog_mode)
        else $error("non-exit code left program mode");
    AST_CMD_PULSE: assert property (wr_ctrl && SFR_REQ.wdata[`FPES_CTRL_WRITE]
        |=> s_ff.cmd_wr ##1 !s_ff.cmd_wr) else $error("start bit is not a one-clock pulse");
    AST_START_CLEARS_DONE: assert property (seq_pgm_start |=> !s_ff.done
        && s_ff.timer == 10'h000) else $error("start did not clear done and timer");
    AST_PAGE_COPY: assert property (seq_pgm_start |=> ##1 FL_CMD.wr ##63 FL_CMD.wr
        ##1 !FL_CMD.wr) else $error("page copy is not 64 writes");
    AST_DONE_BUSY: assert property (s_ff.state != ST_IDLE |-> !s_ff.done)
        else $error("done flag high while operation runs");
    AST_TIMER_STOP: assert property (s_ff.state == ST_WAIT && s_ff.ferst_n
        && s_ff.timer == {2'b00, s_ff.tcmp} |=> s_ff.state == ST_IDLE && s_ff.done)
        else $error("timer match did not end operation");
    AST_BUF_ADVANCE: assert property (wr_data && psel && s_ff.state == ST_IDLE
        && s_ff.pbrst_n |=> s_ff.pidx == $past(s_ff.pidx) + 6'h01)
        else $error("buffer index did not advance");
    AST_BUF_RESET: assert property (!s_ff.pbrst_n && !psel |=> s_ff.pidx == 6'h00)
        else $error("buffer reset did not clear index");
    AST_CTRL_RESET: assert property (!s_ff.ferst_n |=> s_ff.state == ST_IDLE
        && s_ff.done && s_ff.ferst_n) else $error("control reset did not idle the sequencer");
    AST_PLAIN_READ: assert property (s_ff.state == ST_IDLE && s_ff.cmd_rd && plain_mode
        && s_ff.ferst_n |=> FL_CMD.rd ##2 s_ff.data == $past(FL_RDATA))
        else $error("plain read did not load data register");

endmodule : fpes_top

// >>> hw/fpes_regs.svh
// Purpose: Offsets, field positions, reset values and counts of the flash sequencer
// Assumes: Included by the package; definitions only
// Notes: Offsets are special-function-register addresses
`ifndef FPES_REGS_SVH
`define FPES_REGS_SVH
// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define FPES_ADDR_MODE 8'hEA
`define FPES_ADDR_STATUS 8'hEB
`define FPES_ADDR_TCMP 8'hEC
`define FPES_ADDR_PAGE_HIGH 8'hF2
`define FPES_ADDR_PAGE_MID 8'hF3
`define FPES_ADDR_PAGE_LOW 8'hF4
`define FPES_ADDR_DATA 8'hF5
`define FPES_ADDR_CTRL 8'hF6
// ----------------------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------------------
`define FPES_MODE_FSEL 7
`define FPES_MODE_PGM 5
`define FPES_MODE_ERASE 4
`define FPES_MODE_BUFFER_SELECT 3
`define FPES_MODE_OTP_SELECT 2
`define FPES_MODE_VFY 1
`define FPES_MODE_FEEN 0
`define FPES_CTRL_BULK 7
`define FPES_CTRL_WRITE 3
`define FPES_CTRL_READ 2
`define FPES_CTRL_FERST 1
`define FPES_CTRL_PBRST 0
`define FPES_STAT_VGOOD 6
`define FPES_STAT_INT 3
`define FPES_EXIT_CODE 2'h3
`define FPES_ENTRY_FIRST 8'hA5
`define FPES_ENTRY_SECOND 8'h5A
`define FPES_UNLOCK_ADDR_A 16'hF555
`define FPES_UNLOCK_ADDR_B 16'hFAAA
`define FPES_UNLOCK_DATA_1 8'hAA
`define FPES_UNLOCK_DATA_2 8'h55
`define FPES_UNLOCK_DATA_3 8'hA5
`define FPES_ERASED_BYTE 8'hFF
// ----------------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------------
`define FPES_RST_CTRL 8'h03
`define FPES_RST_STATUS 8'h80
`define FPES_PAGE_LAST 6'h3F
`define FPES_PRESCALE_LAST 7'h7F
`endif

// >>> hw/fpes_pkg.sv
// Purpose: Types shared by the flash sequencer
// Assumes: Constants come from fpes_regs.svh
// Notes: Whole block state is one packed struct
`include "fpes_regs.svh"
package fpes_pkg;
    // ------------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_COPY, ST_WAIT, ST_VERIFY} fpes_state_type;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fpes_sfr_req_type;
    typedef struct packed {
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } fpes_mem_wr_type;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
        logic page_erase;
        logic bulk_erase;
        logic otp;
        logic verify;
        logic busy;
    } fpes_flash_cmd_type;
    typedef struct packed {
        fpes_state_type state;
        logic [7:0] mode;
        logic [7:0] tcmp;
        logic [23:0] page_addr;
        logic [7:0] data;
        logic [15:0] direct_addr;
        logic bulk_en;
        logic cmd_wr;
        logic cmd_rd;
        logic ferst_n;
        logic pbrst_n;
        logic done;
        logic vfy_good;
        logic rom_int;
        logic prog_mode;
        logic seen_first;
        logic [1:0] unlock_step;
        logic [5:0] pidx;
        logic [63:0][7:0] pbuf;
        logic [23:0] csum;
        logic [6:0] prescale;
        logic [9:0] timer;
        logic [5:0] widx;
        logic issued_all;
        logic rd_pend;
        logic [15:0] fl_addr;
        logic [7:0] fl_wdata;
        logic fl_wr;
        logic fl_rd;
        logic fl_perase;
        logic fl_berase;
        logic [7:0] rdata;
    } fpes_regs_type;
endpackage : fpes_pkg

// >>> testbench/fpes_flash_model.sv
// Purpose: Behavioural flash array behind the command port
// Assumes: Read data is due the cycle after rd
// Notes: Outside reads the lines toggle, so a sample one cycle late never matches
`timescale 1ns/100ps
module fpes_flash_model (
    input wire logic clk,
    input wire fpes_pkg::fpes_flash_cmd_type cmd,
    output logic [7:0] rdata
);
    import fpes_pkg::*;
    logic [7:0] mem [0:65535];
    initial begin
        rdata = 8'h00;
        for (int i = 0; i < 65536; i++)
            mem[i] = 8'hFF;
    end
    always @(posedge clk) begin
        rdata <= cmd.rd ? mem[cmd.addr] : ~rdata;
        if (cmd.wr)
            mem[cmd.addr] <= cmd.wdata;
        if (cmd.page_erase) begin
            for (int i = 0; i < 64; i++)
                mem[{cmd.addr[15:6], 6'(i)}] <= 8'hFF;
        end
        if (cmd.bulk_erase) begin
            for (int i = 0; i < 65536; i++)
                mem[i] <= 8'hFF;
        end
    end
endmodule : fpes_flash_model

// >>> testbench/flash_program_erase_sequencer_test.sv
// Purpose: Self-checking bench for the flash sequencer
// Assumes: Control writes keep the two active-low bits high, except the 02 and 01 writes that pulse a reset
// Notes: Timer compare of 1 keeps each operation short
`timescale 1ns/100ps
module flash_program_erase_sequencer_test;
    import fpes_pkg::*;
    logic SYS_CLK = 1'b0;
    logic RST = 1'b1;
    logic ONCHIP_DEBUG_MODE = 1'b0;
    fpes_sfr_req_type SFR_REQ = '0;
    fpes_mem_wr_type MEM_WR = '0;
    fpes_flash_cmd_type FL_CMD;
    logic [7:0] SFR_RDATA;
    logic [7:0] FL_RDATA;
    logic [7:0] rv;
    int num_errors = 0;
    int cmp_count = 0;
    always #2 SYS_CLK = ~SYS_CLK;
    fpes_top uut (.SYS_CLK(SYS_CLK), .RST(RST), .CE(1'b1), .SFR_REQ(SFR_REQ),
        .SFR_RDATA(SFR_RDATA), .MEM_WR(MEM_WR), .ONCHIP_DEBUG_MODE(ONCHIP_DEBUG_MODE),
        .FL_CMD(FL_CMD), .FL_RDATA(FL_RDATA));
    fpes_flash_model flash (.clk(SYS_CLK), .cmd(FL_CMD), .rdata(FL_RDATA));
    // ------------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------------
    task automatic end_sim();
        if (num_errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge SYS_CLK);
        SFR_REQ <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge SYS_CLK);
        SFR_REQ.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge SYS_CLK);
        SFR_REQ <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge SYS_CLK);
        SFR_REQ.rd <= 1'b0;
        @(posedge SYS_CLK);
        #1 rv = SFR_RDATA;
    endtask : rd
    task automatic mwr(input logic [15:0] a, input logic [7:0] d, input logic w);
        @(posedge SYS_CLK);
        MEM_WR <= '{wr: w, addr: a, wdata: d};
        @(posedge SYS_CLK);
        MEM_WR.wr <= 1'b0;
    endtask : mwr
    // Address is latched at the control write; byte lands in a few cycles
    task automatic plain(input logic [15:0] a, input logic [7:0] c);
        mwr(a, 8'h00, 1'b0);
        wr(8'hF6, c);
        repeat (8) @(posedge SYS_CLK);
    endtask : plain
    task automatic start_wait(input logic [7:0] c);
        wr(8'hF6, c);
        @(posedge SYS_CLK);
        rd(8'hEB);
        chk(rv & 8'h80, 8'h00);
        chk({7'h00, FL_CMD.busy}, 8'h01);
        for (int i = 0; i < 500; i++) begin
            rd(8'hEB);
            if (rv[7] === 1'b1)
                return;
        end
        num_errors++;
        end_sim();
    endtask : start_wait
    task automatic page_op(input logic [7:0] mode, input int n, input logic [7:0] c);
        wr(8'hEA, 8'h81);
        wr(8'hF6, 8'h02);
        wr(8'hEA, 8'h89);
        for (int i = 0; i < n; i++)
            wr(8'hF5, n == 1 ? 8'h00 : 8'(i * 3 + 1));
        wr(8'hEA, mode);
        wr(8'hF2, 8'h00);
        wr(8'hF3, 8'h12);
        wr(8'hF4, 8'h40);
        wr(8'hEC, 8'h01);
        start_wait(c);
    endtask : page_op
    // Status bit 6 carries the verify verdict once done is back
    task automatic vfy_run(input logic [7:0] mode, input logic [7:0] good);
        wr(8'hEA, mode);
        start_wait(8'h07);
        chk(rv & 8'h40, good);
    endtask : vfy_run
    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        repeat (12) @(posedge SYS_CLK);
        RST <= 1'b0;
        rd(8'hF6);
        chk(rv, 8'h03);
        rd(8'hEB);
        chk(rv, 8'h80);
        wr(8'hF5, 8'h3C);
        plain(16'h1234, 8'h0B);
        chk(flash.mem[16'h1234], 8'h3C);
        wr(8'hF5, 8'h00);
        plain(16'h1234, 8'h07);
        plain(16'h1235, 8'h0B);
        chk(flash.mem[16'h1235], 8'h3C);
        ONCHIP_DEBUG_MODE <= 1'b1;
        mwr(16'hF555, 8'hAA, 1'b1);
        mwr(16'hFAAA, 8'h55, 1'b1);
        mwr(16'hF555, 8'hA5, 1'b1);
        page_op(8'hA1, 64, 8'h0B);
        for (int i = 0; i < 64; i++)
            chk(flash.mem[16'h1240 + i], 8'(i * 3 + 1));
        rd(8'hF4);
        chk(rv, 8'hE0);
        rd(8'hF3);
        chk(rv, 8'h17);
        vfy_run(8'hA3, 8'h40);
        wr(8'hEA, 8'h89);
        wr(8'hF6, 8'h02);
        rd(8'hF4);
        chk(rv, 8'h00);
        rd(8'hF6);
        chk(rv, 8'h03);
        wr(8'hF6, 8'h13);
        page_op(8'h91, 1, 8'h0B);
        for (int i = 0; i < 64; i++)
            chk(flash.mem[16'h1240 + i], 8'hFF);
        chk(flash.mem[16'h1235], 8'h3C);
        vfy_run(8'h93, 8'h40);
        vfy_run(8'hA3, 8'h00);
        wr(8'hF6, 8'h33);
        wr(8'hEA, 8'hA1);
        wr(8'hF6, 8'h0B);
        repeat (2) @(posedge SYS_CLK);
        rd(8'hEB);
        chk(rv & 8'h80, 8'h80);
        wr(8'hF5, 8'hA5);
        wr(8'hF5, 8'h5A);
        page_op(8'h91, 1, 8'h8B);
        chk(flash.mem[16'h1235], 8'hFF);
        // Abort a running erase: done must come back at once
        wr(8'hF6, 8'h0B);
        wr(8'hF6, 8'h01);
        rd(8'hEB);
        chk(rv & 8'h80, 8'h80);
        wr(8'hEA, 8'h85);
        rd(8'hEA);
        chk(rv, 8'h85);
        chk({7'h00, FL_CMD.otp}, 8'h01);
        end_sim();
    end
endmodule : flash_program_erase_sequencer_test
